/* File: inc/qrw_erase_if.sv */
`timescale 1ns/10ps
interface qrw_erase_if;
  logic start;
  logic sector;
  logic busy;
  logic wel_clr;
  modport seq (output start, output sector, input busy, input wel_clr);
  modport tmr (input start, input sector, output busy, output wel_clr);
endinterface : qrw_erase_if

/* File: inc/qrw_pkg.sv */
package qrw_pkg;
  // Opcodes, one bit per clock on IO0
  localparam logic [7:0] OPC_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OPC_SET_WRAP = 8'h77;
  localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  // Frame lengths in serial clocks, minus one
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] QADDR_LAST = 5'h05;
  localparam logic [4:0] MODE_LAST = 5'h01;
  localparam logic [4:0] DUMMY_LAST = 5'h03;
  localparam logic [4:0] SADDR_LAST = 5'h17;
  localparam logic [4:0] WBITS_LAST = 5'h07;
  // Mode byte field and its continue code
  localparam int MODE_SEL_LSB = 4;
  localparam logic [1:0] MODE_CONTINUE = 2'h2;
  // Wrap setting {WRAP_LENGTH_SELECT,W4}, field in the wrap byte
  localparam int WRAP_FIELD_LSB = 4;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam logic [7:0] WRAP_BASE_MASK = 8'h07;
  // Latched command after the opcode
  localparam logic [1:0] OP_WRAP = 2'h0;
  localparam logic [1:0] OP_PAGE = 2'h1;
  localparam logic [1:0] OP_SECTOR = 2'h2;
  // Erase timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int PAGE_ERASE_TIME_US = 1000;
  localparam int SECTOR_ERASE_TIME_US = 5000;
  localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * CLK_FREQ_MHZ;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_OPC = 4'h1,
    ST_QADDR = 4'h2,
    ST_MODE = 4'h3,
    ST_DUMMY = 4'h4,
    ST_DATA = 4'h5,
    ST_SADDR = 4'h6,
    ST_WBITS = 4'h7,
    ST_FULL = 4'h8,
    ST_IGN = 4'h9
  } qrw_state_e;
endpackage : qrw_pkg

/* File: sim/qrw_host.sv */
`timescale 1ns/10ps
module qrw_host (
  // Alignment clock
  input wire logic mclk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io,
  input wire logic [3:0] io_out
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io = 4'h0;
  end
  // Odd offsets keep link edges off the system clock edges
  task sel();
    @(negedge mclk);
    #1.25 cs_n = 1'b0;
    #60;
  endtask : sel
  task desel();
    #60 cs_n = 1'b1;
    #200;
  endtask : desel
  // Drive after the fall, device samples on the rise
  task tick(input logic [3:0] n, output logic [3:0] s);
    io = n;
    #62.5 sclk = 1'b1;
    s = io_out;
    #62.5 sclk = 1'b0;
  endtask : tick
  // Released lines toggle so stale values cannot pass
  task rel(output logic [3:0] s);
    tick(~io, s);
  endtask : rel
  task ser(input logic [31:0] v, input int n);
    logic [3:0] s;
    for (int i = n - 1; i >= 0; i--) tick({3'h0, v[i]}, s);
  endtask : ser
  task quad(input logic [31:0] v, input int n);
    logic [3:0] s;
    for (int i = n - 1; i >= 0; i--) tick(v[4*i+:4], s);
  endtask : quad
endmodule : qrw_host

/* File: sim/tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module tb;
  localparam int PG = 20;
  localparam int SC = 50;
  logic mclk = 1'b0, sys_rst = 1'b1, qe = 1'b0, write_enable_latch = 1'b0, obusy = 1'b0, prot = 1'b0, ce = 1'b1;
  logic cs_n, sclk, wel_clear, write_in_progress, er_start, er_sector, cont_mode;
  logic [3:0] io_in, io_out, io_oe;
  logic [23:0] mem_addr, tgt;
  logic [7:0] mem_rdata;
  logic [2:0] wrap, ew = 3'h1;
  int failures = 0, cmp_count = 0, starts = 0, clears = 0, wip_len = 0;
  always #5 mclk = ~mclk;
  function logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mem
  function logic [23:0] nxt(input logic [23:0] a);
    logic [23:0] m;
    m = (24'h8 << ew[2:1]) - 24'h1;
    if (ew[0]) return a + 24'h1;
    return (a & ~m) | ((a + 24'h1) & m);
  endfunction : nxt
  assign mem_rdata = mem(mem_addr);
  always @(posedge mclk) begin
    if (er_start === 1'b1) starts <= starts + 1;
    if (wel_clear === 1'b1) clears <= clears + 1;
    if (write_in_progress === 1'b1) wip_len <= wip_len + 1;
  end
  qrw_seq #(.AW(24), .PAGE_CYCLES(PG), .SECTOR_CYCLES(SC)) u_qrw_seq (
    .MCLK(mclk), .SYS_RST(sys_rst), .CE(ce), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_ENABLE_BIT(qe), .WRITE_ENABLE_LATCH(write_enable_latch),
    .OTHER_BUSY(obusy), .PROTECT_HIT(prot), .WEL_CLEAR(wel_clear), .WRITE_IN_PROGRESS(write_in_progress),
    .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .ERASE_START(er_start), .ERASE_SECTOR(er_sector),
    .TARGET_ADDR(tgt), .CONT_MODE(cont_mode), .WRAP_SETTING(wrap));
  qrw_host u_qrw_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .io(io_in), .io_out(io_out));
  task qread(input logic [23:0] a, input logic [7:0] m, input int nb, input logic cont, input logic ok);
    logic [3:0] h, l;
    logic [23:0] e;
    e = a;
    u_qrw_host.sel();
    if (!cont) u_qrw_host.ser({24'h0, qrw_pkg::OPC_QUAD_IO_READ}, 8);
    u_qrw_host.quad({8'h0, a}, 6);
    u_qrw_host.quad({24'h0, m}, 2);
    for (int i = 0; i < 4; i++) u_qrw_host.rel(h);
    for (int i = 0; i < nb; i++) begin
      u_qrw_host.rel(h);
      u_qrw_host.rel(l);
      `CHK(io_oe, ok ? 4'hF : 4'h0)
      if (ok) `CHK({h, l}, mem(e))
      e = nxt(e);
    end
    u_qrw_host.desel();
    `CHK(io_oe, 4'h0)
  endtask : qread
  task setwrap(input logic [7:0] w, input int n);
    u_qrw_host.sel();
    u_qrw_host.ser({24'h0, qrw_pkg::OPC_SET_WRAP}, 8);
    u_qrw_host.ser(32'h0, 24);
    u_qrw_host.ser({24'h0, w} >> (8 - n), n);
    u_qrw_host.desel();
    if (n == 8) ew = w[6:4];
    `CHK(wrap, ew)
  endtask : setwrap
  task erase(input logic [7:0] op, input logic [23:0] a, input int nb, input logic ok);
    int s0, c0, w0, n;
    s0 = starts;
    c0 = clears;
    w0 = wip_len;
    n = ok ? (op == 8'h20 ? SC : PG) : 0;
    u_qrw_host.sel();
    u_qrw_host.ser({24'h0, op}, 8);
    u_qrw_host.ser({8'h0, a} >> (nb < 24), nb < 24 ? 23 : 24);
    if (nb > 24) u_qrw_host.ser(32'h1, 1);
    u_qrw_host.desel();
    for (int i = 0; i < 200 && write_in_progress !== 1'b0; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    `CHK(starts - s0, int'(ok))
    `CHK(clears - c0, int'(ok))
    `CHK(wip_len - w0 >= n && wip_len - w0 <= n + 1, 1'b1)
    if (ok) `CHK({er_sector, tgt}, {op == 8'h20, a})
  endtask : erase
  task stop_test();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #900000;
    failures++;
    stop_test();
  end
  initial begin
    int seed;
    logic [23:0] a;
    seed = $urandom(32'h40E8);
    repeat (5) @(posedge mclk);
    @(negedge mclk) sys_rst = 1'b0;
    `CHK({wrap, write_in_progress, cont_mode, io_oe}, {qrw_pkg::WRAP_RESET, 6'h00})
    repeat (5) @(negedge mclk);
    qe = 1'b1;
    for (int i = 0; i < 3; i++) qread(24'($urandom), 8'($urandom) & 8'hDF, 3, 0, 1);
    qread(24'hFFFFFE, 8'h00, 4, 0, 1);
    @(negedge mclk) qe = 1'b0;
    qread(24'($urandom), 8'h00, 2, 0, 0);
    @(negedge mclk) {qe, obusy, write_enable_latch} = 3'h7;
    qread(24'($urandom), 8'h00, 2, 0, 0);
    erase(qrw_pkg::OPC_PAGE_ERASE, 24'($urandom), 24, 0);
    @(negedge mclk) obusy = 1'b0;
    qread(24'($urandom), 8'h20 | (8'($urandom) & 8'hCF), 2, 0, 1);
    `CHK(cont_mode, 1'b1)
    qread(24'($urandom), 8'h20, 2, 1, 1);
    qread(24'($urandom), 8'h30, 2, 1, 1);
    `CHK(cont_mode, 1'b0)
    qread(24'($urandom), 8'h20, 1, 0, 1);
    @(negedge mclk) ce = 1'b0;
    u_qrw_host.sel();
    u_qrw_host.quad(32'h0, 3);
    u_qrw_host.desel();
    @(negedge mclk) ce = 1'b1;
    `CHK(cont_mode, 1'b1)
    u_qrw_host.sel();
    u_qrw_host.quad(32'h0, 3);
    u_qrw_host.desel();
    `CHK(cont_mode, 1'b0)
    qread(24'($urandom), 8'h00, 1, 0, 1);
    for (int w = 0; w < 4; w++) begin
      setwrap({1'b0, 2'(w), 5'h0}, 8);
      repeat (2) qread(24'($urandom), 8'h00, (8 << w) + 2, 0, 1);
    end
    setwrap(8'h10, 7);
    setwrap(8'h10, 8);
    qread(24'($urandom), 8'h00, 3, 0, 1);
    a = 24'($urandom);
    erase(qrw_pkg::OPC_PAGE_ERASE, a, 24, 1);
    erase(qrw_pkg::OPC_SECTOR_ERASE, ~a, 24, 1);
    @(negedge mclk) write_enable_latch = 1'b0;
    erase(qrw_pkg::OPC_SECTOR_ERASE, a, 24, 0);
    @(negedge mclk) {write_enable_latch, prot} = 2'h3;
    erase(qrw_pkg::OPC_PAGE_ERASE, a, 24, 0);
    @(negedge mclk) prot = 1'b0;
    erase(8'h3C, a, 24, 0);
    erase(qrw_pkg::OPC_PAGE_ERASE, a, 23, 0);
    erase(qrw_pkg::OPC_SECTOR_ERASE, a, 25, 0);
    stop_test();
  end
endmodule : tb

/* File: src/qrw_erase_timer.sv */
`timescale 1ns/10ps
module qrw_erase_timer #(
  parameter int PAGE_CYCLES = qrw_pkg::PAGE_ERASE_CYCLES,
  parameter int SECTOR_CYCLES = qrw_pkg::SECTOR_ERASE_CYCLES
) (
  // Clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Erase handshake
  qrw_erase_if.tmr er
);
  logic [31:0] cnt_q;
  logic busy_q;
  logic wel_clr_q;

  assign er.busy = busy_q;
  assign er.wel_clr = wel_clr_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 32'h0;
    end else if (ce) begin
      if (er.start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= er.sector ? 32'(SECTOR_CYCLES - 1) : 32'(PAGE_CYCLES - 1);
      end else if (busy_q) begin
        if (cnt_q == 32'h0) begin
          busy_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 32'h1;
        end
      end
    end
  end

  // Latch drops right at the start, well before completion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wel_clr_q <= 1'b0;
    end else if (ce) begin
      wel_clr_q <= er.start && !busy_q;
    end
  end

  AST_ERASE_BEGINS: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && er.start && !busy_q) |=> (busy_q && wel_clr_q))
    else $error("erase start did not raise busy and clear the latch");
  AST_ERASE_ENDS: assert property (@(posedge mclk) disable iff (sys_rst)
    (ce && busy_q && cnt_q == 32'h0) |=> !busy_q)
    else $error("erase busy did not fall at end of count");
  COV_ERASE_DONE: cover property (@(posedge mclk) disable iff (sys_rst) $fell(busy_q));
endmodule : qrw_erase_timer

/* File: src/qrw_seq.sv */
`timescale 1ns/10ps
module qrw_seq #(
  parameter int AW = 24,
  parameter int PAGE_CYCLES = qrw_pkg::PAGE_ERASE_CYCLES,
  parameter int SECTOR_CYCLES = qrw_pkg::SECTOR_ERASE_CYCLES
) (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // Serial pins
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  // Status to and from the status register logic
  input wire logic QUAD_ENABLE_BIT,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic OTHER_BUSY,
  input wire logic PROTECT_HIT,
  output logic WEL_CLEAR,
  output logic WRITE_IN_PROGRESS,
  // Array read port
  output logic [AW-1:0] MEM_ADDR,
  input wire logic [7:0] MEM_RDATA,
  // Erase request and state views
  output logic ERASE_START,
  output logic ERASE_SECTOR,
  output logic [AW-1:0] TARGET_ADDR,
  output logic CONT_MODE,
  output logic [2:0] WRAP_SETTING
);
  qrw_pkg::qrw_state_e state_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic [3:0] io_s1_q, io_s2_q;
  logic [4:0] cnt_q;
  logic [7:0] sr_q;
  logic [1:0] op_q;
  logic [AW-1:0] addr_q;
  logic cont_q;
  logic [2:0] wrap_q;
  logic nib_q;
  logic [3:0] io_out_q;
  logic [3:0] oe_q;
  logic start_q;
  logic sector_q;
  logic [7:0] opc_now;
  logic cs_fall, cs_rise, sck_rise, sck_fall, busy_all;

  qrw_erase_if er ();

  qrw_erase_timer #(
    .PAGE_CYCLES(PAGE_CYCLES),
    .SECTOR_CYCLES(SECTOR_CYCLES)
  ) u_timer (
    .mclk(MCLK),
    .sys_rst(SYS_RST),
    .ce(CE),
    .er(er)
  );

  // Window aware increment; windows are aligned to their length
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic [2:0] w);
    logic [AW-1:0] inc;
    logic [AW-1:0] mask;
    inc = a + AW'(1);
    // Low bits that move inside the window, length minus one
    mask = ((AW'(qrw_pkg::WRAP_BASE_MASK) + AW'(1)) << w[2:1]) - AW'(1);
    if (w[0]) begin
      next_addr = inc;
    end else begin
      next_addr = (a & ~mask) | (inc & mask);
    end
  endfunction : next_addr

  // Two stages on every pin before any logic looks at them
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else if (CE) begin
      cs_s1_q <= CS_N;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sck_s1_q <= SCLK;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      io_s1_q <= IO_IN;
      io_s2_q <= io_s1_q;
    end
  end

  assign cs_fall = cs_s3_q && !cs_s2_q;
  assign cs_rise = !cs_s3_q && cs_s2_q;
  assign sck_rise = !cs_s2_q && !sck_s3_q && sck_s2_q;
  assign sck_fall = !cs_s2_q && sck_s3_q && !sck_s2_q;
  assign busy_all = er.busy || OTHER_BUSY;
  assign opc_now = {sr_q[6:0], io_s2_q[0]};

  // Frame sequencing; chip select edges take priority over clock edges
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_q <= qrw_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sr_q <= 8'h00;
      op_q <= qrw_pkg::OP_WRAP;
    end else if (CE) begin
      if (cs_rise) begin
        state_q <= qrw_pkg::ST_IDLE;
      end else if (cs_fall) begin
        cnt_q <= 5'h00;
        state_q <= cont_q ? qrw_pkg::ST_QADDR : qrw_pkg::ST_OPC;
      end else if (sck_rise) begin
        cnt_q <= cnt_q + 5'h01;
        unique case (state_q)
          qrw_pkg::ST_OPC: begin
            sr_q <= opc_now;
            if (cnt_q == qrw_pkg::OPC_LAST) begin
              cnt_q <= 5'h00;
              if (opc_now == qrw_pkg::OPC_QUAD_IO_READ) begin
                state_q <= (QUAD_ENABLE_BIT && !busy_all) ? qrw_pkg::ST_QADDR : qrw_pkg::ST_IGN;
              end else if (opc_now == qrw_pkg::OPC_SET_WRAP) begin
                op_q <= qrw_pkg::OP_WRAP;
                state_q <= qrw_pkg::ST_SADDR;
              end else if (opc_now == qrw_pkg::OPC_PAGE_ERASE) begin
                op_q <= qrw_pkg::OP_PAGE;
                state_q <= qrw_pkg::ST_SADDR;
              end else if (opc_now == qrw_pkg::OPC_SECTOR_ERASE) begin
                op_q <= qrw_pkg::OP_SECTOR;
                state_q <= qrw_pkg::ST_SADDR;
              end else begin
                state_q <= qrw_pkg::ST_IGN;
              end
            end
          end
          qrw_pkg::ST_QADDR: begin
            if (cnt_q == qrw_pkg::QADDR_LAST) begin
              cnt_q <= 5'h00;
              state_q <= qrw_pkg::ST_MODE;
            end
          end
          qrw_pkg::ST_MODE: begin
            sr_q <= {sr_q[3:0], io_s2_q};
            if (cnt_q == qrw_pkg::MODE_LAST) begin
              cnt_q <= 5'h00;
              state_q <= qrw_pkg::ST_DUMMY;
            end
          end
          qrw_pkg::ST_DUMMY: begin
            if (cnt_q == qrw_pkg::DUMMY_LAST) begin
              state_q <= qrw_pkg::ST_DATA;
            end
          end
          qrw_pkg::ST_SADDR: begin
            if (cnt_q == qrw_pkg::SADDR_LAST) begin
              cnt_q <= 5'h00;
              state_q <= (op_q == qrw_pkg::OP_WRAP) ? qrw_pkg::ST_WBITS : qrw_pkg::ST_FULL;
            end
          end
          qrw_pkg::ST_WBITS: begin
            sr_q <= opc_now;
            if (cnt_q == qrw_pkg::WBITS_LAST) begin
              state_q <= qrw_pkg::ST_FULL;
            end
          end
          // A clock past the frame end spoils the frame
          qrw_pkg::ST_FULL: state_q <= qrw_pkg::ST_IGN;
          qrw_pkg::ST_IDLE, qrw_pkg::ST_DATA, qrw_pkg::ST_IGN: state_q <= state_q;
          default: state_q <= qrw_pkg::ST_IGN;
        endcase
      end
    end
  end

  // Address shifter; also the read pointer during data
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      addr_q <= '0;
    end else if (CE) begin
      if (sck_rise && state_q == qrw_pkg::ST_QADDR) begin
        addr_q <= {addr_q[AW-5:0], io_s2_q};
      end else if (sck_rise && state_q == qrw_pkg::ST_SADDR && op_q != qrw_pkg::OP_WRAP) begin
        addr_q <= {addr_q[AW-2:0], io_s2_q[0]};
      end else if (sck_fall && state_q == qrw_pkg::ST_DATA && nib_q) begin
        addr_q <= next_addr(addr_q, wrap_q);
      end
    end
  end

  // Mode bits decide the next frame's opening at select release
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cont_q <= 1'b0;
    end else if (CE && cs_rise) begin
      if (state_q == qrw_pkg::ST_DUMMY || state_q == qrw_pkg::ST_DATA) begin
        cont_q <= (sr_q[qrw_pkg::MODE_SEL_LSB+:2] == qrw_pkg::MODE_CONTINUE);
      end else if (cont_q && state_q == qrw_pkg::ST_QADDR) begin
        // Select raised inside the address is the mode reset sequence
        cont_q <= 1'b0;
      end
    end
  end

  // Wrap setting lives across frames
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      wrap_q <= qrw_pkg::WRAP_RESET;
    end else if (CE && cs_rise && state_q == qrw_pkg::ST_FULL && op_q == qrw_pkg::OP_WRAP) begin
      wrap_q <= sr_q[qrw_pkg::WRAP_FIELD_LSB+:3];
    end
  end

  // Data out; a fresh byte is sampled for each high nibble
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      nib_q <= 1'b0;
      io_out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (CE) begin
      if (cs_rise || cs_fall) begin
        nib_q <= 1'b0;
        oe_q <= 4'h0;
      end else if (sck_fall && state_q == qrw_pkg::ST_DATA) begin
        nib_q <= !nib_q;
        oe_q <= 4'hF;
        io_out_q <= nib_q ? MEM_RDATA[3:0] : MEM_RDATA[7:4];
      end
    end
  end

  // Erase launch; only a frame ending exactly at the last address bit
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      start_q <= 1'b0;
      sector_q <= 1'b0;
    end else if (CE) begin
      start_q <= cs_rise && state_q == qrw_pkg::ST_FULL && op_q != qrw_pkg::OP_WRAP
                 && WRITE_ENABLE_LATCH && !PROTECT_HIT && !busy_all;
      if (cs_rise && state_q == qrw_pkg::ST_FULL) begin
        sector_q <= (op_q == qrw_pkg::OP_SECTOR);
      end
    end
  end

  assign er.start = start_q;
  assign er.sector = sector_q;
  assign IO_OUT = io_out_q;
  assign IO_OE = oe_q;
  assign WEL_CLEAR = er.wel_clr;
  assign WRITE_IN_PROGRESS = er.busy;
  assign MEM_ADDR = addr_q;
  assign TARGET_ADDR = addr_q;
  assign ERASE_START = start_q;
  assign ERASE_SECTOR = sector_q;
  assign CONT_MODE = cont_q;
  assign WRAP_SETTING = wrap_q;

  AST_STOP_DRIVE: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && cs_rise) |=> (oe_q == 4'h0))
    else $error("data lines still driven after select rose");
  AST_QE_REFUSE: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && sck_rise && !cs_rise && !cs_fall && state_q == qrw_pkg::ST_OPC && cnt_q == qrw_pkg::OPC_LAST
     && opc_now == qrw_pkg::OPC_QUAD_IO_READ && !QUAD_ENABLE_BIT) |=> state_q == qrw_pkg::ST_IGN)
    else $error("quad read taken without quad enable");
  AST_BUSY_REFUSE: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_q == qrw_pkg::ST_QADDR && $past(state_q) == qrw_pkg::ST_OPC) |-> !$past(busy_all))
    else $error("quad read taken while busy");
  AST_ADDR_STEP: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && sck_fall && state_q == qrw_pkg::ST_DATA && nib_q && wrap_q[0]) |=> addr_q == $past(addr_q) + AW'(1))
    else $error("linear read address did not step by one");
  AST_WRAP_WINDOW: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && sck_fall && state_q == qrw_pkg::ST_DATA && nib_q && !wrap_q[0])
    |=> addr_q[AW-1:6] == $past(addr_q[AW-1:6]))
    else $error("wrapped read left its window");
  AST_CONT_ENTRY: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && cs_fall && !cs_rise && cont_q) |=> state_q == qrw_pkg::ST_QADDR)
    else $error("continuous frame did not open with address");
  AST_ERASE_GATE: assert property (@(posedge MCLK) disable iff (SYS_RST)
    ($past(CE) && start_q)
    |-> ($past(state_q) == qrw_pkg::ST_FULL && $past(WRITE_ENABLE_LATCH) && !$past(PROTECT_HIT)))
    else $error("erase started from a bad frame");
  AST_DATA_AFTER_DUMMY: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_q == qrw_pkg::ST_DATA && $past(state_q) == qrw_pkg::ST_DUMMY) |-> $past(cnt_q) == qrw_pkg::DUMMY_LAST)
    else $error("data began before dummy clocks ended");
  AST_CONT_EXIT: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && cs_rise && state_q == qrw_pkg::ST_DATA
     && sr_q[qrw_pkg::MODE_SEL_LSB+:2] != qrw_pkg::MODE_CONTINUE) |=> !cont_q)
    else $error("other mode bits kept continuous read");
  AST_CONT_RESET: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && cs_rise && cont_q && state_q == qrw_pkg::ST_QADDR) |=> !cont_q)
    else $error("mode reset sequence did not clear continuous read");
  AST_OE_IN_DATA: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (oe_q != 4'h0) |-> (oe_q == 4'hF && state_q == qrw_pkg::ST_DATA))
    else $error("data lines driven outside the data phase");
  AST_WRAP_HOLD: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !(CE && cs_rise && state_q == qrw_pkg::ST_FULL && op_q == qrw_pkg::OP_WRAP) |=> $stable(wrap_q))
    else $error("wrap setting changed outside a set-wrap frame");
  // One cycle wide, so the timer never sees a second start
  AST_ERASE_PULSE: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && start_q) |=> !start_q)
    else $error("erase start held longer than one cycle");
  AST_ADDR_SHIFT: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CE && sck_rise && state_q == qrw_pkg::ST_QADDR) |=> addr_q[3:0] == $past(io_s2_q))
    else $error("address nibble not taken into the low bits");

  COV_CONT_FRAME: cover property (@(posedge MCLK) disable iff (SYS_RST) cs_fall && cont_q);
  COV_ERASE: cover property (@(posedge MCLK) disable iff (SYS_RST) start_q && sector_q);
  COV_WRAP_SET: cover property (@(posedge MCLK) disable iff (SYS_RST) $changed(wrap_q));
  COV_WRAP_READ: cover property (@(posedge MCLK) disable iff (SYS_RST) state_q == qrw_pkg::ST_DATA && !wrap_q[0]);
endmodule : qrw_seq
